// ### rtl/pss_regs.sv
// Register bank, reference modes and threshold events of the sensor port.
// Assumes a conversion engine on core_clk and an external serial master.
// How it works
// - A one-register read is 16 clocks; each extra byte adds 8.
// - Device shifts the addressed byte out in bits 8 to 15, MSB first.
// - Master sends bits 8 to 15; device stores that byte.
// - Further read bytes follow, one per extra 8-clock block.
// - Wire mode bit set returns read data on the shared data line.
// - Three-wire mode supports multi-byte reads the same way.
// - Registers are 8 bits, picked by a 7-bit index, over serial.
// - Factory values reload at power-up; master leaves them alone.
// - Threshold events only with enable set; threshold at 0C and 0D.
// - High enable fires above threshold, low enable below minus threshold.
// - Latch bit keeps causes until read; clear means no latching.
// - With a reference mode on, compare measured minus reference.
// - Zero mode stores measured as reference; output is the difference.
// - Zero mode enable bit clears after the first conversion.
// - Zero clear bit ends zero mode and wipes the reference.
// - Auto mode stores reference; output is measured minus offset*256.
// - Auto mode enable bit clears after the first conversion.
// - Auto clear bit ends auto mode and restores normal output.
// - Address steps per extra byte when step enable is 1.
// - Drive on falling edge, sample on rising; clock idles high.
`timescale 1ns/1ps
module pss_regs
  import pss_pkg::*;
#(
  parameter logic [7:0] IDENTITY_VALUE = 8'h5A // Arbitrary value
) (
  // Core clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Serial link pins
  input  wire logic        serial_shift_clock,
  input  wire logic        chip_sel_n,
  input  wire logic        sdi_in,
  output logic             sdi_out,
  output logic             sdi_oe,
  output logic             sdo_out,
  output logic             sdo_oe,
  // Conversion results
  input  wire logic        meas_valid,
  input  wire logic [23:0] meas_pressure,
  input  wire logic [15:0] meas_temperature,
  // Threshold interrupt
  output logic             threshold_irq
);
  typedef struct packed {
    logic [7:0]  interrupt_config;
    logic [15:0] pressure_threshold;
    logic [7:0]  control_one;
    logic [7:0]  control_two;
    logic [7:0]  interrupt_control;
    logic [7:0]  queue_control;
    logic [23:0] reference_pressure;
    logic [15:0] pressure_offset_value;
    logic [7:0]  resolution_config;
    logic [7:0]  interrupt_cause;
    logic [7:0]  sample_state;
    logic [23:0] pressure_output;
    logic [15:0] temperature_output;
    logic        mode_zero;
    logic        mode_auto;
    logic [1:0]  cs_sync;
    logic [2:0]  gray_s1;
    logic [2:0]  gray_s2;
    logic [2:0]  seen;
    logic        pend_v;
    logic [23:0] pend_p;
    logic [15:0] pend_t;
  } pss_core_t;

  pss_core_t          r, n;
  logic [6:0]         rd_addr;
  logic [7:0]         rd_data;
  logic [2:0]         byte_gray;
  logic [6:0]         byte_addr;
  logic [7:0]         byte_data;
  logic               byte_write;
  logic               frame_on;
  logic               ev_pend;
  logic               wr_ev;
  logic               conv;
  logic               mapped;
  logic [23:0]        cp;
  logic [15:0]        ct;
  logic [23:0]        ref_now;
  logic               zero_now;
  logic               auto_now;
  logic [23:0]        diff;
  logic signed [24:0] diff_s;
  logic signed [24:0] thr_s;
  logic               hit_high;
  logic               hit_low;
  logic [7:0]         fresh;

  // Link side engine on the master's clock
  pss_spi_link u_link (
    .rst                (rst),
    .serial_shift_clock (serial_shift_clock),
    .chip_sel_n         (chip_sel_n),
    .sdi_in             (sdi_in),
    .sdi_out            (sdi_out),
    .sdi_oe             (sdi_oe),
    .sdo_out            (sdo_out),
    .sdo_oe             (sdo_oe),
    .wire_mode_select   (r.control_one[C1_WIRE_MODE]),
    .address_step       (r.control_two[C2_ADDR_STEP]),
    .rd_addr            (rd_addr),
    .rd_data            (rd_data),
    .byte_gray          (byte_gray),
    .byte_addr          (byte_addr),
    .byte_data          (byte_data),
    .byte_write         (byte_write)
  );

  // Read mux; readable state is frozen during a frame, so this is stable
  always_comb begin
    mapped = 1'b1;
    unique case (rd_addr)
      ADR_INTERRUPT_CONFIG: rd_data = r.interrupt_config;
      ADR_THRESHOLD_LOW:    rd_data = r.pressure_threshold[7:0];
      ADR_THRESHOLD_HIGH:   rd_data = r.pressure_threshold[15:8];
      ADR_IDENTITY:         rd_data = IDENTITY_VALUE;
      ADR_CONTROL_ONE:      rd_data = r.control_one;
      ADR_CONTROL_TWO:      rd_data = r.control_two;
      ADR_INTERRUPT_CTRL:   rd_data = r.interrupt_control;
      ADR_QUEUE_CONTROL:    rd_data = r.queue_control;
      ADR_REFERENCE_XLOW:   rd_data = r.reference_pressure[7:0];
      ADR_REFERENCE_LOW:    rd_data = r.reference_pressure[15:8];
      ADR_REFERENCE_HIGH:   rd_data = r.reference_pressure[23:16];
      ADR_OFFSET_LOW:       rd_data = r.pressure_offset_value[7:0];
      ADR_OFFSET_HIGH:      rd_data = r.pressure_offset_value[15:8];
      ADR_RESOLUTION:       rd_data = r.resolution_config;
      ADR_INTERRUPT_CAUSE:  rd_data = r.interrupt_cause;
      ADR_SAMPLE_STATE:     rd_data = r.sample_state;
      ADR_PRESSURE_XLOW:    rd_data = r.pressure_output[7:0];
      ADR_PRESSURE_LOW:     rd_data = r.pressure_output[15:8];
      ADR_PRESSURE_HIGH:    rd_data = r.pressure_output[23:16];
      ADR_TEMP_LOW:         rd_data = r.temperature_output[7:0];
      ADR_TEMP_HIGH:        rd_data = r.temperature_output[15:8];
      // Queue and filter logic are absent here; they read as zero
      ADR_QUEUE_STATE:      rd_data = RST_ZERO;
      ADR_FILTER_RESET:     rd_data = RST_ZERO;
      default: begin
        rd_data = RST_ZERO;
        mapped = 1'b0;
      end
    endcase
  end

  // Frame and byte events seen from the core side
  assign frame_on = !r.cs_sync[1];
  assign ev_pend  = (r.gray_s2 != pss_gray(r.seen));
  assign wr_ev    = ev_pend && byte_write;
  // Conversions wait for the frame to end so reads never tear
  assign conv     = !frame_on && (meas_valid || r.pend_v);
  assign cp       = meas_valid ? meas_pressure : r.pend_p;
  assign ct       = meas_valid ? meas_temperature : r.pend_t;

  // Reference selection for this conversion
  always_comb begin
    ref_now  = r.reference_pressure;
    zero_now = r.mode_zero;
    auto_now = r.mode_auto;
    if (r.interrupt_config[IC_ZERO_ENABLE]) begin
      ref_now  = cp;
      zero_now = 1'b1;
    end
    if (r.interrupt_config[IC_AUTO_ENABLE]) begin
      ref_now  = cp;
      auto_now = 1'b1;
    end
    diff = (zero_now || auto_now) ? cp - ref_now : cp;
  end

  // Threshold is scaled into the pressure LSB range before comparing
  assign diff_s   = {diff[23], diff};
  assign thr_s    = {1'b0, r.pressure_threshold, OFFSET_PAD};
  assign hit_high = (diff_s > thr_s);
  assign hit_low  = (diff_s < -thr_s);

  // Fresh causes, gated by the enables
  always_comb begin
    fresh = RST_ZERO;
    if (r.interrupt_config[IC_THRESH_EN]) begin
      fresh[CAUSE_HIGH] = r.interrupt_config[IC_HIGH_EVENT] && hit_high;
      fresh[CAUSE_LOW]  = r.interrupt_config[IC_LOW_EVENT] && hit_low;
    end
    fresh[CAUSE_ACTIVE] = fresh[CAUSE_HIGH] || fresh[CAUSE_LOW];
  end

  // Next state: byte events first, then a conversion, so sets win
  always_comb begin
    n = r;
    n.cs_sync = {r.cs_sync[0], chip_sel_n};
    n.gray_s1 = byte_gray;
    n.gray_s2 = r.gray_s1;
    if (frame_on && meas_valid) begin
      n.pend_v = 1'b1;
      n.pend_p = meas_pressure;
      n.pend_t = meas_temperature;
    end
    if (ev_pend) begin
      n.seen = r.seen + 3'h1;
      if (byte_write) begin
        unique case (byte_addr)
          ADR_INTERRUPT_CONFIG: begin
            // Clear bits act once and are never stored
            n.interrupt_config = byte_data;
            n.interrupt_config[IC_ZERO_CLEAR] = 1'b0;
            n.interrupt_config[IC_AUTO_CLEAR] = 1'b0;
            if (byte_data[IC_ZERO_CLEAR]) begin
              n.mode_zero = 1'b0;
              n.reference_pressure = '0;
            end
            if (byte_data[IC_AUTO_CLEAR]) begin
              n.mode_auto = 1'b0;
            end
          end
          ADR_THRESHOLD_LOW:  n.pressure_threshold[7:0] = byte_data;
          ADR_THRESHOLD_HIGH: n.pressure_threshold[15:8] = byte_data;
          ADR_CONTROL_ONE:    n.control_one = byte_data;
          ADR_CONTROL_TWO:    n.control_two = byte_data;
          ADR_INTERRUPT_CTRL: n.interrupt_control = byte_data;
          ADR_QUEUE_CONTROL:  n.queue_control = byte_data;
          ADR_REFERENCE_XLOW: n.reference_pressure[7:0] = byte_data;
          ADR_REFERENCE_LOW:  n.reference_pressure[15:8] = byte_data;
          ADR_REFERENCE_HIGH: n.reference_pressure[23:16] = byte_data;
          ADR_OFFSET_LOW:     n.pressure_offset_value[7:0] = byte_data;
          ADR_OFFSET_HIGH:    n.pressure_offset_value[15:8] = byte_data;
          ADR_RESOLUTION:     n.resolution_config = byte_data;
          default: ; // Read-only and reserved: dropped
        endcase
      end else begin
        // Reads that consume status
        if (byte_addr == ADR_INTERRUPT_CAUSE) begin
          n.interrupt_cause = RST_ZERO;
        end
        if (byte_addr == ADR_PRESSURE_HIGH) begin
          n.sample_state[STAT_PRESSURE] = 1'b0;
        end
        if (byte_addr == ADR_TEMP_HIGH) begin
          n.sample_state[STAT_TEMP] = 1'b0;
        end
      end
    end
    if (conv) begin
      n.pend_v = 1'b0;
      n.reference_pressure = ref_now;
      n.mode_zero = zero_now;
      n.mode_auto = auto_now;
      // Enable bits fall after the conversion they started
      n.interrupt_config[IC_ZERO_ENABLE] = 1'b0;
      n.interrupt_config[IC_AUTO_ENABLE] = 1'b0;
      if (zero_now) begin
        n.pressure_output = cp - ref_now;
      end else if (auto_now) begin
        n.pressure_output = cp - {r.pressure_offset_value, OFFSET_PAD};
      end else begin
        n.pressure_output = cp;
      end
      n.temperature_output = ct;
      n.sample_state[STAT_PRESSURE] = 1'b1;
      n.sample_state[STAT_TEMP] = 1'b1;
      if (r.interrupt_config[IC_LATCH]) begin
        n.interrupt_cause = n.interrupt_cause | fresh;
      end else begin
        n.interrupt_cause = fresh;
      end
    end
  end

  // State register; reset stands in for the power-up reload
  always_ff @(posedge core_clk) begin
    if (rst) begin
      r <= '0;
      r.control_two <= RST_CONTROL_TWO;
      r.cs_sync <= 2'h3;
    end else begin
      r <= n;
    end
  end

  assign threshold_irq = r.interrupt_cause[CAUSE_ACTIVE];

  // Checks

  property p_wr_store;
    @(posedge core_clk) disable iff (rst)
      wr_ev && byte_addr == ADR_THRESHOLD_LOW
      |=> r.pressure_threshold[7:0] == $past(byte_data);
  endproperty
  a_wr_store: assert property (p_wr_store)
    else $error("threshold low byte not stored");

  property p_ro_keep;
    @(posedge core_clk) disable iff (rst)
      wr_ev && byte_addr == ADR_PRESSURE_HIGH && !conv
      |=> $stable(r.pressure_output);
  endproperty
  a_ro_keep: assert property (p_ro_keep)
    else $error("write changed a read-only register");

  property p_rd_zero;
    @(posedge core_clk) disable iff (rst)
      !mapped |-> rd_data == RST_ZERO;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("reserved index read nonzero");

  property p_zero_take;
    @(posedge core_clk) disable iff (rst)
      conv && r.interrupt_config[IC_ZERO_ENABLE]
      |=> r.mode_zero && r.pressure_output == '0
          && r.reference_pressure == $past(cp);
  endproperty
  a_zero_take: assert property (p_zero_take)
    else $error("zero mode did not capture reference");

  property p_zero_self;
    @(posedge core_clk) disable iff (rst)
      conv && r.interrupt_config[IC_ZERO_ENABLE] && !wr_ev
      |=> !r.interrupt_config[IC_ZERO_ENABLE];
  endproperty
  a_zero_self: assert property (p_zero_self)
    else $error("zero enable bit did not self clear");

  property p_zero_clr;
    @(posedge core_clk) disable iff (rst)
      wr_ev && byte_addr == ADR_INTERRUPT_CONFIG
      && byte_data[IC_ZERO_CLEAR] && !conv
      |=> !r.mode_zero && r.reference_pressure == '0;
  endproperty
  a_zero_clr: assert property (p_zero_clr)
    else $error("zero clear left mode or reference");

  property p_auto_out;
    @(posedge core_clk) disable iff (rst)
      conv && r.interrupt_config[IC_AUTO_ENABLE]
      && !r.interrupt_config[IC_ZERO_ENABLE] && !r.mode_zero
      |=> r.mode_auto && !r.interrupt_config[IC_AUTO_ENABLE]
          && r.pressure_output == $past(cp)
             - {$past(r.pressure_offset_value), OFFSET_PAD};
  endproperty
  a_auto_out: assert property (p_auto_out)
    else $error("auto mode output wrong");

  property p_auto_clr;
    @(posedge core_clk) disable iff (rst)
      wr_ev && byte_addr == ADR_INTERRUPT_CONFIG
      && byte_data[IC_AUTO_CLEAR] && !conv
      |=> !r.mode_auto;
  endproperty
  a_auto_clr: assert property (p_auto_clr)
    else $error("auto clear did not end auto mode");

  property p_gate;
    @(posedge core_clk) disable iff (rst)
      conv && !r.interrupt_config[IC_THRESH_EN]
      && !r.interrupt_config[IC_LATCH]
      |=> r.interrupt_cause == RST_ZERO && !threshold_irq;
  endproperty
  a_gate: assert property (p_gate)
    else $error("event raised while threshold irq disabled");

  property p_high_fire;
    @(posedge core_clk) disable iff (rst)
      conv && r.interrupt_config[IC_THRESH_EN]
      && r.interrupt_config[IC_HIGH_EVENT] && hit_high
      |=> threshold_irq && r.interrupt_cause[CAUSE_HIGH];
  endproperty
  a_high_fire: assert property (p_high_fire)
    else $error("high event missed");

  property p_latch;
    @(posedge core_clk) disable iff (rst)
      r.interrupt_config[IC_LATCH] && threshold_irq && !ev_pend
      |=> threshold_irq;
  endproperty
  a_latch: assert property (p_latch)
    else $error("latched cause dropped");

  property p_freeze;
    @(posedge core_clk) disable iff (rst)
      frame_on ##1 frame_on |-> $stable(r.pressure_output);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("output changed during a frame");
endmodule : pss_regs

// ### rtl/pss_pkg.sv
// Constants shared by the pressure sensor serial register port.
// Assumes 7-bit register indices and 8-bit registers throughout.
package pss_pkg;
  // Register indices
  localparam logic [6:0] ADR_INTERRUPT_CONFIG = 7'h0B;
  localparam logic [6:0] ADR_THRESHOLD_LOW    = 7'h0C;
  localparam logic [6:0] ADR_THRESHOLD_HIGH   = 7'h0D;
  localparam logic [6:0] ADR_IDENTITY         = 7'h0F;
  localparam logic [6:0] ADR_CONTROL_ONE      = 7'h10;
  localparam logic [6:0] ADR_CONTROL_TWO      = 7'h11;
  localparam logic [6:0] ADR_INTERRUPT_CTRL   = 7'h12;
  localparam logic [6:0] ADR_QUEUE_CONTROL    = 7'h14;
  localparam logic [6:0] ADR_REFERENCE_XLOW   = 7'h15;
  localparam logic [6:0] ADR_REFERENCE_LOW    = 7'h16;
  localparam logic [6:0] ADR_REFERENCE_HIGH   = 7'h17;
  localparam logic [6:0] ADR_OFFSET_LOW       = 7'h18;
  localparam logic [6:0] ADR_OFFSET_HIGH      = 7'h19;
  localparam logic [6:0] ADR_RESOLUTION       = 7'h1A;
  localparam logic [6:0] ADR_INTERRUPT_CAUSE  = 7'h25;
  localparam logic [6:0] ADR_QUEUE_STATE      = 7'h26;
  localparam logic [6:0] ADR_SAMPLE_STATE     = 7'h27;
  localparam logic [6:0] ADR_PRESSURE_XLOW    = 7'h28;
  localparam logic [6:0] ADR_PRESSURE_LOW     = 7'h29;
  localparam logic [6:0] ADR_PRESSURE_HIGH    = 7'h2A;
  localparam logic [6:0] ADR_TEMP_LOW         = 7'h2B;
  localparam logic [6:0] ADR_TEMP_HIGH        = 7'h2C;
  localparam logic [6:0] ADR_FILTER_RESET     = 7'h33;
  // Field positions of interrupt_config
  localparam int unsigned IC_HIGH_EVENT   = 0;
  localparam int unsigned IC_LOW_EVENT    = 1;
  localparam int unsigned IC_LATCH        = 2;
  localparam int unsigned IC_THRESH_EN    = 3;
  localparam int unsigned IC_ZERO_CLEAR   = 4;
  localparam int unsigned IC_ZERO_ENABLE  = 5;
  localparam int unsigned IC_AUTO_CLEAR   = 6;
  localparam int unsigned IC_AUTO_ENABLE  = 7;
  // Other field positions
  localparam int unsigned C1_WIRE_MODE    = 0;
  localparam int unsigned C2_ADDR_STEP    = 4;
  localparam int unsigned CAUSE_HIGH      = 0;
  localparam int unsigned CAUSE_LOW       = 1;
  localparam int unsigned CAUSE_ACTIVE    = 2;
  localparam int unsigned STAT_PRESSURE   = 0;
  localparam int unsigned STAT_TEMP       = 1;
  // Reset values and fixed patterns
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [7:0] RST_CONTROL_TWO = 8'h10;
  localparam logic [7:0] OFFSET_PAD      = 8'h00;
  localparam logic [2:0] BIT_LAST        = 3'h7;
  // Gray code of a byte count
  function automatic logic [2:0] pss_gray(input logic [2:0] b);
    return b ^ {1'b0, b[2:1]};
  endfunction : pss_gray
endpackage : pss_pkg

// ### rtl/pss_spi_link.sv
// Serial frame engine running on the master's shift clock.
// Assumes chip select frames every transfer and core levels are quasi-static.
`timescale 1ns/1ps
module pss_spi_link
  import pss_pkg::*;
(
  // Resets and link clock
  input  wire logic       rst,
  input  wire logic       serial_shift_clock,
  input  wire logic       chip_sel_n,
  // Data pins
  input  wire logic       sdi_in,
  output logic            sdi_out,
  output logic            sdi_oe,
  output logic            sdo_out,
  output logic            sdo_oe,
  // Levels from the core
  input  wire logic       wire_mode_select,
  input  wire logic       address_step,
  // Read port into the register bank
  output logic [6:0]      rd_addr,
  input  wire logic [7:0] rd_data,
  // Completed byte towards the core
  output logic [2:0]      byte_gray,
  output logic [6:0]      byte_addr,
  output logic [7:0]      byte_data,
  output logic            byte_write
);
  typedef struct packed {
    logic       hdr;
    logic       rw;
    logic [2:0] cnt;
    logic [6:0] shift;
    logic [6:0] addr;
  } pss_frm_t;
  typedef struct packed {
    logic [2:0] bcnt;
    logic [2:0] gray;
    logic [6:0] addr;
    logic [7:0] data;
    logic       wr;
    logic [1:0] wm_sync;
    logic [1:0] inc_sync;
  } pss_evt_t;
  typedef struct packed {
    logic       drive;
    logic [7:0] osh;
  } pss_out_t;

  pss_frm_t f_r, f_nxt;
  pss_evt_t e_r, e_nxt;
  pss_out_t o_r, o_nxt;
  logic     frame_clr;

  // Frame state dies with chip select, so a cut byte never lands
  assign frame_clr = rst | chip_sel_n;

  // Sample on rising edges; header first, then whole data bytes
  always_comb begin
    f_nxt = f_r;
    e_nxt = e_r;
    f_nxt.cnt = f_r.cnt + 3'h1;
    f_nxt.shift = {f_r.shift[5:0], sdi_in};
    e_nxt.wm_sync = {e_r.wm_sync[0], wire_mode_select};
    e_nxt.inc_sync = {e_r.inc_sync[0], address_step};
    if (f_r.cnt == BIT_LAST) begin
      if (!f_r.hdr) begin
        f_nxt.hdr = 1'b1;
        f_nxt.rw = f_r.shift[6];
        f_nxt.addr = {f_r.shift[5:0], sdi_in};
      end else begin
        // Each full block of 8 is one byte event
        e_nxt.bcnt = e_r.bcnt + 3'h1;
        e_nxt.gray = pss_gray(e_nxt.bcnt);
        e_nxt.addr = f_r.addr;
        e_nxt.data = {f_r.shift, sdi_in};
        e_nxt.wr = !f_r.rw;
        if (e_r.inc_sync[1]) begin
          f_nxt.addr = f_r.addr + 7'h01;
        end
      end
    end
  end

  // Drive on falling edges: load at each byte start, else shift
  always_comb begin
    o_nxt = o_r;
    o_nxt.osh = {o_r.osh[6:0], 1'b0};
    if (f_r.hdr && f_r.rw && f_r.cnt == 3'h0) begin
      o_nxt.osh = rd_data;
      o_nxt.drive = 1'b1;
    end
  end

  // Frame registers, cleared between frames
  always_ff @(posedge serial_shift_clock or posedge frame_clr) begin
    if (frame_clr) f_r <= '0;
    else f_r <= f_nxt;
  end

  // Byte events outlive the frame so the core can still take the last one
  always_ff @(posedge serial_shift_clock or posedge rst) begin
    if (rst) e_r <= '0;
    else e_r <= e_nxt;
  end

  // Output shifter on the falling edge
  always_ff @(negedge serial_shift_clock or posedge frame_clr) begin
    if (frame_clr) o_r <= '0;
    else o_r <= o_nxt;
  end

  // Pin selection by wire mode
  assign sdo_out    = o_r.osh[7];
  assign sdo_oe     = o_r.drive & ~e_r.wm_sync[1];
  assign sdi_out    = o_r.osh[7];
  assign sdi_oe     = o_r.drive & e_r.wm_sync[1];
  assign rd_addr    = f_r.addr;
  assign byte_gray  = e_r.gray;
  assign byte_addr  = e_r.addr;
  assign byte_data  = e_r.data;
  assign byte_write = e_r.wr;
endmodule : pss_spi_link

// ### sim/pss_spi_master.sv
// Serial master partner: frames of whole bytes on a 15 ns shift clock.
// Assumes the bench resolves the shared data line and calls frame.
`timescale 1ns/1ps
module pss_spi_master (
  // Master pins
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  // Clock and select idle high
  // Set after time zero starts so the link's clears see a rising edge
  initial begin
    sck  <= 1'b1;
    cs_n <= 1'b1;
    mosi <= 1'b0;
  end
  // Command byte then n data bytes, MSB first; no reserved writes
  task automatic frame(input logic rd, input logic [6:0] a, input int n,
                       input logic [15:0] wd, output logic [15:0] q);
    logic [7:0] b;
    cs_n = 1'b0;
    #300;
    for (int k = 0; k <= n; k++) begin
      b = (k == 0) ? {rd, a} : wd[23-8*k -: 8];
      for (int i = 7; i >= 0; i--) begin
        sck  = 1'b0;
        mosi = (rd && k > 0) ? ~mosi : b[i]; // Toggles so stale data never reads as valid
        #7.5 sck = 1'b1;
        q = {q[14:0], miso};
        #7.5;
      end
      #700; // Gap lets each byte cross into the core
    end
    #300 cs_n = 1'b1;
    #300;
  endtask : frame
endmodule : pss_spi_master

// ### sim/pss_regs_bench.sv
// Bench for the sensor register port: frames, references, threshold events.
// Assumes the master model above and the core conversion port.
`timescale 1ns/1ps
module pss_regs_bench import pss_pkg::*;;
  logic        core_clk = 1'b0;
  logic        rst = 1'b0;
  logic        meas_valid = 1'b0;
  logic [23:0] meas_pressure = 24'h0;
  logic [15:0] meas_temperature = 16'h0;
  logic        wire3 = 1'b0;
  logic [15:0] q;
  wire         sck, cs_n, mosi, sdi_out, sdi_oe, sdo_out, sdo_oe, threshold_irq;
  int          n_errors = 0;
  int          check_count = 0;
  // Undriven sdi line carries the master bit; undriven sdo line shows its inverse
  wire sdi_line = sdi_oe ? sdi_out : mosi;
  wire sdo_line = sdo_oe ? sdo_out : ~mosi;
  always #50 core_clk = ~core_clk;
  pss_spi_master pss_spi_master_i (.sck(sck), .cs_n(cs_n), .mosi(mosi),
    .miso(wire3 ? sdi_line : sdo_line));
  pss_regs pss_regs_i (.core_clk(core_clk), .rst(rst), .serial_shift_clock(sck),
    .chip_sel_n(cs_n), .sdi_in(sdi_line), .sdi_out(sdi_out), .sdi_oe(sdi_oe),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .meas_valid(meas_valid),
    .meas_pressure(meas_pressure), .meas_temperature(meas_temperature),
    .threshold_irq(threshold_irq));
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task rd(input string nm, input logic [6:0] a, input int n, input logic [15:0] exp);
    pss_spi_master_i.frame(1'b1, a, n, 16'h0, q);
    check(nm, (n == 1) ? {8'h00, q[7:0]} : q, exp);
  endtask : rd
  task wr(input logic [6:0] a, input int n, input logic [15:0] wd);
    pss_spi_master_i.frame(1'b0, a, n, wd, q);
  endtask : wr
  task conv(input logic [23:0] p, input logic irq);
    @(posedge core_clk);
    meas_pressure    <= p;
    meas_temperature <= p[15:0];
    meas_valid       <= 1'b1;
    @(posedge core_clk);
    meas_valid <= 1'b0;
    @(posedge core_clk);
    check("threshold_irq", {15'h0, threshold_irq}, {15'h0, irq});
  endtask : conv
  task t_regs;
    rd("control_two", ADR_CONTROL_TWO, 1, {8'h00, RST_CONTROL_TWO});
    rd("identity", ADR_IDENTITY, 1, 16'h005A);
    wr(ADR_THRESHOLD_LOW, 2, 16'h1234);
    rd("threshold", ADR_THRESHOLD_LOW, 2, 16'h1234);
    wr(ADR_CONTROL_TWO, 1, 16'h0000);
    rd("fixed index", ADR_THRESHOLD_HIGH, 2, 16'h3434);
    wr(ADR_CONTROL_TWO, 1, 16'h1000);
    wr(ADR_IDENTITY, 1, 16'hFF00);
    rd("identity ro", ADR_IDENTITY, 1, 16'h005A);
    wr(ADR_PRESSURE_HIGH, 1, 16'hFF00);
    rd("pressure ro", ADR_PRESSURE_HIGH, 1, 16'h0000);
    rd("reserved", 7'h0E, 1, 16'h0000);
  endtask : t_regs
  task t_events;
    wr(ADR_THRESHOLD_LOW, 2, 16'h0100);
    wr(ADR_INTERRUPT_CONFIG, 1, 16'h0900);
    conv(24'h000200, 1'b1);
    rd("pressure", ADR_PRESSURE_XLOW, 2, 16'h0002);
    conv(24'h000050, 1'b0);
    wr(ADR_INTERRUPT_CONFIG, 1, 16'h2100);
    conv(24'h123456, 1'b0);
    conv(24'h123460, 1'b0);
    rd("diff output", ADR_PRESSURE_XLOW, 2, 16'h0A00);
    rd("zero enable", ADR_INTERRUPT_CONFIG, 1, 16'h0001);
    rd("reference", ADR_REFERENCE_XLOW, 2, 16'h5634);
    wr(ADR_INTERRUPT_CONFIG, 1, 16'h1000);
    rd("ref cleared", ADR_REFERENCE_XLOW, 2, 16'h0000);
  endtask : t_events
  // Auto reference with offset, latched low events, status and temperature
  task t_modes;
    wr(ADR_OFFSET_LOW, 2, 16'h0200);
    wr(ADR_INTERRUPT_CONFIG, 1, 16'h8E00);
    conv(24'h001000, 1'b0);
    rd("auto output", ADR_PRESSURE_XLOW, 2, 16'h000E);
    conv(24'h000E00, 1'b1);
    conv(24'h001000, 1'b1);
    rd("cause", ADR_INTERRUPT_CAUSE, 1, 16'h0006);
    conv(24'h001000, 1'b0);
    rd("status", ADR_SAMPLE_STATE, 1, 16'h0003);
    rd("temperature", ADR_TEMP_LOW, 2, 16'h0010);
    wr(ADR_INTERRUPT_CONFIG, 1, 16'h4000);
    conv(24'h001000, 1'b0);
    rd("auto cleared", ADR_PRESSURE_XLOW, 2, 16'h0010);
  endtask : t_modes
  task t_wire3;
    wr(ADR_CONTROL_ONE, 1, 16'h0100);
    wire3 = 1'b1;
    rd("identity 3w", ADR_IDENTITY, 1, 16'h005A);
    rd("threshold 3w", ADR_THRESHOLD_LOW, 2, 16'h0100);
    wr(ADR_CONTROL_ONE, 1, 16'h0000);
    wire3 = 1'b0;
  endtask : t_wire3
  task print_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  // Main sequence after a three-cycle reset
  initial begin
    rst <= 1'b1; // Rising edge also clears the link side flops
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    t_regs;
    t_events;
    t_modes;
    t_wire3;
    print_verdict;
  end
  // Watchdog well beyond the roughly 100 us of traffic
  initial begin
    #400000;
    n_errors++;
    print_verdict;
  end
endmodule : pss_regs_bench
